// file: src/ebac_mem.sv
// byte array behind the controller, registered read data
`timescale 1ns/1ps
module ebac_mem
    import ebac_pkg::*;
#(
    parameter int AW = EBAC_ADDR_W
) (
    input  wire logic          mclk_i,
    input  wire logic [AW-1:0] addr_i,
    input  wire logic          rd_i,
    input  wire logic          wr_i,
    input  wire logic          erase_i,
    input  wire logic [7:0]    wdata_i,
    output logic      [7:0]    rdata_o
);
    logic [7:0] mem [0:(1<<AW)-1];

    // erase sets all ones, write-only ands like a cell program
    always_ff @(posedge mclk_i) begin
        if (wr_i && erase_i) begin
            mem[addr_i] <= wdata_i;
        end else if (erase_i) begin
            mem[addr_i] <= 8'hFF;
        end else if (wr_i) begin
            mem[addr_i] <= mem[addr_i] & wdata_i;
        end
    end

    // registered read port
    always_ff @(posedge mclk_i) begin
        if (rd_i) begin
            rdata_o <= mem[addr_i];
        end
    end
endmodule

// file: src/ebac_pkg.sv
// constants and types shared by the eeprom byte access controller
package ebac_pkg;
    // ========================================================
    // register selects on the core i/o port
    localparam logic [1:0] EBAC_SEL_CTRL   = 2'h0;
    localparam logic [1:0] EBAC_SEL_DATA   = 2'h1;
    localparam logic [1:0] EBAC_SEL_ADDR_L = 2'h2;
    localparam logic [1:0] EBAC_SEL_ADDR_H = 2'h3;
    // ========================================================
    // control register fields, address widths and reset values
    localparam int EBAC_BIT_RDSTB  = 0;
    localparam int EBAC_BIT_WRSTB  = 1;
    localparam int EBAC_BIT_MWE    = 2;
    localparam int EBAC_BIT_RIE    = 3;
    localparam int EBAC_BIT_PM_LO  = 4;
    localparam int EBAC_BIT_PM_HI  = 5;
    localparam int EBAC_ADDR_W     = 11;
    localparam int EBAC_ADDR_HI_W  = 3;
    localparam logic [1:0] EBAC_PM_RESET = 2'h0;
    localparam logic [7:0] EBAC_DATA_RESET = 8'h00;
    // ========================================================
    // programming modes
    typedef enum logic [1:0] {
        EBAC_PM_ATOMIC = 2'h0,
        EBAC_PM_ERASE  = 2'h1,
        EBAC_PM_WRITE  = 2'h2,
        EBAC_PM_RSVD   = 2'h3
    } ebac_pm_t;
    // ========================================================
    // timing
    localparam int EBAC_READ_STALL   = 4;
    localparam int EBAC_WRITE_STALL  = 2;
    localparam int EBAC_MWE_WINDOW   = 4;
    localparam int EBAC_OSC_CYC_FULL = 26368;  // oscillator cycles, atomic write
    localparam int EBAC_T_FULL_US    = 3400;   // 3.4 ms
    localparam int EBAC_T_HALF_US    = 1800;   // 1.8 ms
    localparam int EBAC_OSC_CYC_HALF =
        (EBAC_OSC_CYC_FULL * EBAC_T_HALF_US) / EBAC_T_FULL_US;
    localparam int EBAC_CLK_MHZ      = 200;
    localparam int EBAC_OSC_KHZ      = 8000;   // calibrated rc oscillator
    localparam int EBAC_OSC_DIV      = (EBAC_CLK_MHZ * 1000) / EBAC_OSC_KHZ;
    // ========================================================
    // controller states, one-hot
    typedef enum logic [2:0] {
        EBAC_ST_IDLE  = 3'b001,
        EBAC_ST_READ  = 3'b010,
        EBAC_ST_PROG  = 3'b100
    } ebac_state_t;
endpackage

// file: src/ebac_prog_timer.sv
// self-timed programming counter clocked by oscillator enable pulses
`timescale 1ns/1ps
module ebac_prog_timer
    import ebac_pkg::*;
#(
    parameter int OSC_DIV  = EBAC_OSC_DIV,
    parameter int CYC_FULL = EBAC_OSC_CYC_FULL,
    parameter int CYC_HALF = EBAC_OSC_CYC_HALF
) (
    input  wire logic mclk_i,
    input  wire logic rstn_i,
    input  wire logic start_i,
    input  wire logic full_i,
    output logic      busy_o,
    output logic      done_o
);
    localparam int DW = $clog2(OSC_DIV + 1);
    localparam int CW = $clog2(CYC_FULL + 1);
    logic [DW-1:0] div_r;
    logic          tick;
    logic [CW-1:0] cnt_r;

    // oscillator-rate enable from the core clock
    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            div_r <= '0;
        end else if (div_r == DW'(OSC_DIV - 1)) begin
            div_r <= '0;
        end else begin
            div_r <= div_r + 1'b1;
        end
    end
    assign tick = (div_r == DW'(OSC_DIV - 1));

    // count oscillator cycles of the selected duration
    // no reset here: a running write outlives a core reset, and an unknown
    // busy at power-up falls into the idle branch and settles in one cycle
    always_ff @(posedge mclk_i) begin
        done_o <= 1'b0;
        if (busy_o) begin
            if (tick) begin
                if (cnt_r == CW'(1)) begin
                    busy_o <= 1'b0;
                    done_o <= 1'b1;
                end
                cnt_r <= cnt_r - 1'b1;
            end
        end else begin
            busy_o <= start_i;
            cnt_r  <= full_i ? CW'(CYC_FULL) : CW'(CYC_HALF);
        end
    end
endmodule

// file: src/ebac_top.sv
// eeprom byte access controller: register file, strobes, stall and ready irq
`timescale 1ns/1ps
module ebac_top
    import ebac_pkg::*;
#(
    parameter int OSC_DIV  = EBAC_OSC_DIV,
    parameter int CYC_FULL = EBAC_OSC_CYC_FULL,
    parameter int CYC_HALF = EBAC_OSC_CYC_HALF
) (
    input  wire logic       mclk_i,
    input  wire logic       rstn_i,
    input  wire logic       io_sel_i,
    input  wire logic [1:0] io_addr_i,
    input  wire logic       io_wr_i,
    input  wire logic       io_rd_i,
    input  wire logic [7:0] io_wdata_i,
    output logic      [7:0] io_rdata_o,
    output logic            core_stall_o,
    input  wire logic       global_irq_en_i,
    input  wire logic       flash_self_program_enable_i,
    output logic            ready_irq_o
);
    // ========================================================
    // state
    logic [EBAC_ADDR_W-1:0] byte_address_field_r;
    logic [7:0]             data_byte_register_r;
    logic [1:0]             program_mode_bits_r;
    logic                   ready_irq_enable_r;
    logic                   mwe_r;
    logic                   wrstb_r;
    logic                   wrstb_view;
    logic                   read_strobe_r;
    logic [2:0]             mwe_cnt_r;
    logic [2:0]             stall_cnt_r;
    logic                   rd_pending_r;
    ebac_state_t            state_r;
    ebac_state_t            state_nxt;
    logic                   wr_ctrl;
    logic                   start_wr;
    logic                   start_rd;
    logic                   prog_busy;
    logic                   prog_done;
    logic                   prog_go_r;
    logic [7:0]             mem_rdata;
    logic                   mem_wr;
    logic                   mem_erase;

    // decode of a write to one register select
    // all operands are arguments so continuous assigns track them
    function automatic logic sel_wr(input logic       s,
                                    input logic       w,
                                    input logic [1:0] a,
                                    input logic [1:0] sel);
        return s && w && (a == sel);
    endfunction

    assign wr_ctrl = sel_wr(io_sel_i, io_wr_i, io_addr_i, EBAC_SEL_CTRL);
    // write accepted only inside the master enable window
    assign start_wr = wr_ctrl && io_wdata_i[EBAC_BIT_WRSTB] && mwe_r && !wrstb_view
                      && !flash_self_program_enable_i;
    assign start_rd = wr_ctrl && io_wdata_i[EBAC_BIT_RDSTB] && !wrstb_view
                      && !start_wr;

    // ========================================================
    // controller sequencing
    always_comb begin
        state_nxt = state_r;
        case (state_r)
            EBAC_ST_IDLE: begin
                if (start_wr) begin
                    state_nxt = EBAC_ST_PROG;
                end else if (start_rd) begin
                    state_nxt = EBAC_ST_READ;
                end
            end
            EBAC_ST_READ: begin
                state_nxt = EBAC_ST_IDLE;
            end
            EBAC_ST_PROG: begin
                if (prog_done) begin
                    state_nxt = EBAC_ST_IDLE;
                end
            end
            default: begin
                state_nxt = EBAC_ST_IDLE;
            end
        endcase
    end

    // a reset returns the sequencer to idle, even during programming
    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            state_r <= EBAC_ST_IDLE;
        end else begin
            state_r <= state_nxt;
        end
    end

    // ========================================================
    // address register, no reset value
    always_ff @(posedge mclk_i) begin
        if (!wrstb_view) begin
            if (sel_wr(io_sel_i, io_wr_i, io_addr_i, EBAC_SEL_ADDR_L)) begin
                byte_address_field_r[7:0] <= io_wdata_i;
            end
            if (sel_wr(io_sel_i, io_wr_i, io_addr_i, EBAC_SEL_ADDR_H)) begin
                byte_address_field_r[EBAC_ADDR_W-1:8] <=
                    io_wdata_i[EBAC_ADDR_HI_W-1:0];
            end
        end
    end

    // ========================================================
    // data register: written by software, loaded by reads
    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            data_byte_register_r <= EBAC_DATA_RESET;
        end else if (rd_pending_r) begin
            data_byte_register_r <= mem_rdata;
        end else if (sel_wr(io_sel_i, io_wr_i, io_addr_i, EBAC_SEL_DATA)) begin
            data_byte_register_r <= io_wdata_i;
        end
    end

    // ========================================================
    // mode bits, held through reset while programming
    always_ff @(posedge mclk_i) begin
        if (!rstn_i) begin
            if (!prog_busy) begin
                program_mode_bits_r <= EBAC_PM_RESET;
            end
        end else if (wr_ctrl && !wrstb_view) begin
            program_mode_bits_r <= io_wdata_i[EBAC_BIT_PM_HI:EBAC_BIT_PM_LO];
        end
    end

    // ready interrupt enable
    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            ready_irq_enable_r <= 1'b0;
        end else if (wr_ctrl) begin
            ready_irq_enable_r <= io_wdata_i[EBAC_BIT_RIE];
        end
    end

    // ========================================================
    // master write enable with four-cycle timeout
    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            mwe_r     <= 1'b0;
            mwe_cnt_r <= '0;
        end else if (wr_ctrl && io_wdata_i[EBAC_BIT_MWE] && !io_wdata_i[EBAC_BIT_WRSTB]) begin
            mwe_r     <= 1'b1;
            mwe_cnt_r <= 3'(EBAC_MWE_WINDOW);
        end else if (start_wr) begin
            mwe_r     <= 1'b0;
            mwe_cnt_r <= '0;
        end else if (mwe_r) begin
            if (mwe_cnt_r == 3'(1)) begin
                mwe_r <= 1'b0;
            end
            mwe_cnt_r <= mwe_cnt_r - 3'(1);
        end
    end

    // ========================================================
    // write strobe: set on an accepted start, cleared at the end
    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            wrstb_r <= 1'b0;
        end else if (start_wr) begin
            wrstb_r <= 1'b1;
        end else if (prog_done) begin
            wrstb_r <= 1'b0;
        end
    end

    // write strobe view stays set while a write survives reset
    assign wrstb_view = wrstb_r || prog_busy;

    // read strobe self-clears after one cycle
    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            read_strobe_r <= 1'b0;
            rd_pending_r  <= 1'b0;
        end else begin
            read_strobe_r <= start_rd;
            rd_pending_r  <= start_rd;
            if (read_strobe_r) begin
                read_strobe_r <= 1'b0;
            end
        end
    end

    // ========================================================
    // core stall counter
    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            stall_cnt_r <= '0;
        end else if (start_rd) begin
            stall_cnt_r <= 3'(EBAC_READ_STALL);
        end else if (start_wr) begin
            stall_cnt_r <= 3'(EBAC_WRITE_STALL);
        end else if (stall_cnt_r != '0) begin
            stall_cnt_r <= stall_cnt_r - 3'(1);
        end
    end
    assign core_stall_o = (stall_cnt_r != '0);

    // ========================================================
    // programming start and cell controls
    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            prog_go_r <= 1'b0;
        end else begin
            prog_go_r <= start_wr && (program_mode_bits_r != EBAC_PM_RSVD);
        end
    end
    assign mem_wr    = prog_done && ((program_mode_bits_r == EBAC_PM_ATOMIC)
                       || (program_mode_bits_r == EBAC_PM_WRITE));
    assign mem_erase = prog_done && ((program_mode_bits_r == EBAC_PM_ATOMIC)
                       || (program_mode_bits_r == EBAC_PM_ERASE));

    // reserved mode still finishes with a done so the strobe drops
    logic rsvd_done_r;
    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            rsvd_done_r <= 1'b0;
        end else begin
            rsvd_done_r <= start_wr && (program_mode_bits_r == EBAC_PM_RSVD);
        end
    end

    logic timer_done;
    assign prog_done = timer_done || rsvd_done_r;

    // self-timed duration from the oscillator rate
    ebac_prog_timer #(
        .OSC_DIV  (OSC_DIV),
        .CYC_FULL (CYC_FULL),
        .CYC_HALF (CYC_HALF)
    ) u_timer (
        .mclk_i  (mclk_i),
        .rstn_i  (rstn_i),
        .start_i (prog_go_r),
        .full_i  (program_mode_bits_r == EBAC_PM_ATOMIC),
        .busy_o  (prog_busy),
        .done_o  (timer_done)
    );

    // storage array
    ebac_mem #(
        .AW (EBAC_ADDR_W)
    ) u_mem (
        .mclk_i  (mclk_i),
        .addr_i  (byte_address_field_r),
        .rd_i    (start_rd),
        .wr_i    (mem_wr),
        .erase_i (mem_erase),
        .wdata_i (data_byte_register_r),
        .rdata_o (mem_rdata)
    );

    // ========================================================
    // ready interrupt, level while idle
    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            ready_irq_o <= 1'b0;
        end else begin
            ready_irq_o <= ready_irq_enable_r && global_irq_en_i && !wrstb_view
                           && !flash_self_program_enable_i;
        end
    end

    // ========================================================
    // register read mux
    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            io_rdata_o <= 8'h00;
        end else if (io_sel_i && io_rd_i) begin
            case (io_addr_i)
                EBAC_SEL_CTRL:
                    io_rdata_o <= {2'b00, program_mode_bits_r, ready_irq_enable_r,
                                   mwe_r, wrstb_view, read_strobe_r};
                EBAC_SEL_DATA:
                    io_rdata_o <= data_byte_register_r;
                EBAC_SEL_ADDR_L:
                    io_rdata_o <= byte_address_field_r[7:0];
                EBAC_SEL_ADDR_H:
                    io_rdata_o <= {5'b0_0000, byte_address_field_r[EBAC_ADDR_W-1:8]};
                default:
                    io_rdata_o <= 8'h00;
            endcase
        end
    end
endmodule

// file: verif/ebac_assertions.sv
// port checks for the eeprom byte access controller
`timescale 1ns/1ps
module ebac_checker
    import ebac_pkg::*;
(
    input wire logic       mclk_i,
    input wire logic       rstn_i,
    input wire logic       io_sel_i,
    input wire logic [1:0] io_addr_i,
    input wire logic       io_wr_i,
    input wire logic       io_rd_i,
    input wire logic [7:0] io_wdata_i,
    input wire logic [7:0] io_rdata_o,
    input wire logic       core_stall_o,
    input wire logic       global_irq_en_i,
    input wire logic       flash_self_program_enable_i,
    input wire logic       ready_irq_o
);
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (!rstn_i);
    // ====
    // decoded accesses
    wire ctl_wr = io_sel_i & io_wr_i & (io_addr_i == EBAC_SEL_CTRL);
    wire ctl_rd = io_sel_i & io_rd_i & (io_addr_i == EBAC_SEL_CTRL);
    wire hi_rd  = io_sel_i & io_rd_i & (io_addr_i == EBAC_SEL_ADDR_H);
    wire rd_go  = ctl_wr & io_wdata_i[0] & ~io_wdata_i[1];
    logic [3:0] age_r;
    wire wr_go = ctl_wr & io_wdata_i[1] & ~io_wdata_i[0] & (age_r < 4'h3)
                 & ~flash_self_program_enable_i;
    // cycles since master enable was set, saturating
    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            age_r <= 4'hF;
        end else if (ctl_wr && io_wdata_i[2] && !io_wdata_i[1]) begin
            age_r <= 4'h0;
        end else if (age_r != 4'hF) begin
            age_r <= age_r + 4'h1;
        end
    end
    // ====
    // assertions
    a_read_stall: assert property (rd_go |=> core_stall_o [*4] ##1 !core_stall_o)
        else $error("read stall length wrong");
    a_write_stall: assert property (wr_go |=> core_stall_o [*2] ##1 !core_stall_o)
        else $error("write stall length wrong");
    a_stall_cause: assert property (!core_stall_o && !ctl_wr |=> !core_stall_o)
        else $error("stall without strobe");
    a_irq_global: assert property (!global_irq_en_i |=> !ready_irq_o)
        else $error("irq with global enable off");
    a_irq_flash: assert property (flash_self_program_enable_i |=> !ready_irq_o)
        else $error("irq during flash program");
    a_irq_busy: assert property (wr_go && io_wdata_i[5:4] != 2'h3 |=> ##1 !ready_irq_o [*8])
        else $error("irq during write");
    a_addr_upper: assert property (hi_rd |=> io_rdata_o[7:3] == 5'h00)
        else $error("address high reserved bits set");
    a_ctrl_rsvd: assert property (ctl_rd |=> io_rdata_o[7:6] == 2'h0)
        else $error("control reserved bits set");
    a_rdstb_clear: assert property (ctl_rd |=> !io_rdata_o[0])
        else $error("read strobe stuck");
    a_mwe_expire: assert property (ctl_rd && age_r == 4'hF |=> !io_rdata_o[2])
        else $error("master enable not expired");
endmodule

bind ebac_top ebac_checker i_chk (
    .mclk_i(mclk_i), .rstn_i(rstn_i), .io_sel_i(io_sel_i), .io_addr_i(io_addr_i),
    .io_wr_i(io_wr_i), .io_rd_i(io_rd_i), .io_wdata_i(io_wdata_i), .io_rdata_o(io_rdata_o),
    .core_stall_o(core_stall_o), .global_irq_en_i(global_irq_en_i),
    .flash_self_program_enable_i(flash_self_program_enable_i), .ready_irq_o(ready_irq_o)
);

// file: verif/ebac_core_model.sv
// core model issuing register accesses on the i/o port
`timescale 1ns/1ps
module ebac_core_model
    import ebac_pkg::*;
(
    input  wire logic       mclk_i,
    input  wire logic       core_stall_i,
    input  wire logic [7:0] io_rdata_i,
    output logic            io_sel_o,
    output logic      [1:0] io_addr_o,
    output logic            io_wr_o,
    output logic            io_rd_o,
    output logic      [7:0] io_wdata_o
);
    // ====
    // idle port at time zero
    initial begin
        io_sel_o   = 1'b0;
        io_addr_o  = 2'h0;
        io_wr_o    = 1'b0;
        io_rd_o    = 1'b0;
        io_wdata_o = 8'h00;
    end
    // one register write, then sit halted while the stall holds
    task automatic wr(input logic [1:0] a, input logic [7:0] d);
        @(posedge mclk_i);
        io_sel_o   <= 1'b1;
        io_wr_o    <= 1'b1;
        io_addr_o  <= a;
        io_wdata_o <= d;
        @(posedge mclk_i);
        io_sel_o   <= 1'b0;
        io_wr_o    <= 1'b0;
        io_wdata_o <= ~d;
        @(posedge mclk_i);
        #1;
        while (core_stall_i !== 1'b0) begin
            @(posedge mclk_i);
            #1;
        end
    endtask
    // one register read, data taken the cycle after
    task automatic rd(input logic [1:0] a, output logic [7:0] d);
        @(posedge mclk_i);
        io_sel_o  <= 1'b1;
        io_rd_o   <= 1'b1;
        io_addr_o <= a;
        @(posedge mclk_i);
        io_sel_o <= 1'b0;
        io_rd_o  <= 1'b0;
        #1;
        d = io_rdata_i;
    endtask
endmodule

// file: verif/testbench.sv
// self-checking bench for the eeprom byte access controller
`timescale 1ns/1ps
module testbench
    import ebac_pkg::*;
;
    localparam int DIV = 2;
    localparam int FULL = 20;
    localparam int HALF = 10;
    logic       mclk_i;
    logic       rstn_i;
    logic       glb_ie;
    logic       flash_en;
    logic       sel, wr, rd, stall, irq;
    logic [1:0] addr;
    logic [7:0] wdata, rdata, v;
    int         err_count, compares, cyc, t0, el;
    // ====
    // clock and cycle count
    initial begin
        mclk_i = 1'b0;
        forever #2.5 mclk_i = ~mclk_i;
    end
    always @(posedge mclk_i) cyc <= cyc + 1;
    ebac_top #(.OSC_DIV(DIV), .CYC_FULL(FULL), .CYC_HALF(HALF)) i_dut (
        .mclk_i(mclk_i), .rstn_i(rstn_i), .io_sel_i(sel), .io_addr_i(addr), .io_wr_i(wr),
        .io_rd_i(rd), .io_wdata_i(wdata), .io_rdata_o(rdata), .core_stall_o(stall),
        .global_irq_en_i(glb_ie), .flash_self_program_enable_i(flash_en), .ready_irq_o(irq));
    ebac_core_model i_core (
        .mclk_i(mclk_i), .core_stall_i(stall), .io_rdata_i(rdata), .io_sel_o(sel),
        .io_addr_o(addr), .io_wr_o(wr), .io_rd_o(rd), .io_wdata_o(wdata));
    // ====
    // helpers
    task automatic chk(input string n, input logic [7:0] s, input logic [7:0] e);
        compares++;
        if (s !== e) begin
            err_count++;
            $display("MISMATCH %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic end_sim();
        if (err_count == 0 && compares > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    task automatic prog(input logic [1:0] pm, input logic [10:0] a, input logic [7:0] d);
        i_core.wr(EBAC_SEL_ADDR_H, {5'h00, a[10:8]});
        i_core.wr(EBAC_SEL_ADDR_L, a[7:0]);
        i_core.wr(EBAC_SEL_DATA, d);
        i_core.wr(EBAC_SEL_CTRL, {2'h0, pm, 4'h4});
        t0 = cyc;
        i_core.wr(EBAC_SEL_CTRL, {2'h0, pm, 4'h6});
    endtask
    task automatic wait_done();
        v = 8'h02;
        for (int i = 0; i < 100 && v[1] !== 1'b0; i++) i_core.rd(EBAC_SEL_CTRL, v);
        el = cyc - t0;
        chk("strobe_clear", v & 8'h02, 8'h00);
    endtask
    task automatic fetch(input logic [10:0] a);
        i_core.wr(EBAC_SEL_ADDR_H, {5'h00, a[10:8]});
        i_core.wr(EBAC_SEL_ADDR_L, a[7:0]);
        i_core.wr(EBAC_SEL_CTRL, 8'h01);
        i_core.rd(EBAC_SEL_DATA, v);
    endtask
    task automatic pulse_rst();
        @(posedge mclk_i);
        rstn_i <= 1'b0;
        repeat (3) @(posedge mclk_i);
        rstn_i <= 1'b1;
    endtask
    // ====
    // scenarios
    task automatic t_modes();
        logic [1:0] pm [5] = '{2'h0, 2'h1, 2'h2, 2'h2, 2'h3};
        logic [7:0] dv [5] = '{8'h3C, 8'h00, 8'hF5, 8'h3F, 8'h00};
        logic [7:0] ev [5] = '{8'h3C, 8'hFF, 8'hF5, 8'h35, 8'h35};
        int         tm [5] = '{FULL * DIV, HALF * DIV, HALF * DIV, HALF * DIV, 0};
        for (int i = 0; i < 5; i++) begin
            prog(pm[i], 11'h5A3, dv[i]);
            wait_done();
            chk("mode_time", {7'h00, el >= tm[i] - 4 && el <= tm[i] + 16}, 8'h01);
            fetch(11'h5A3);
            chk("mode_data", v, ev[i]);
        end
    endtask
    task automatic t_busy();
        prog(2'h0, 11'h012, 8'h77);
        i_core.wr(EBAC_SEL_CTRL, 8'h20);
        i_core.wr(EBAC_SEL_ADDR_L, 8'hEE);
        i_core.rd(EBAC_SEL_CTRL, v);
        chk("mode_frozen", v & 8'h32, 8'h02);
        wait_done();
        i_core.rd(EBAC_SEL_ADDR_L, v);
        chk("addr_frozen", v, 8'h12);
        i_core.wr(EBAC_SEL_CTRL, 8'h01);
        i_core.rd(EBAC_SEL_DATA, v);
        chk("busy_data", v, 8'h77);
    endtask
    task automatic t_guard();
        i_core.wr(EBAC_SEL_DATA, 8'h55);
        i_core.wr(EBAC_SEL_CTRL, 8'h04);
        repeat (6) @(posedge mclk_i);
        i_core.rd(EBAC_SEL_CTRL, v);
        chk("mwe_expired", v, 8'h00);
        i_core.wr(EBAC_SEL_CTRL, 8'h02);
        i_core.rd(EBAC_SEL_CTRL, v);
        chk("no_mwe", v & 8'h02, 8'h00);
        @(posedge mclk_i);
        flash_en <= 1'b1;
        prog(2'h0, 11'h012, 8'h99);
        i_core.rd(EBAC_SEL_CTRL, v);
        chk("flash_block", v & 8'h02, 8'h00);
        @(posedge mclk_i);
        flash_en <= 1'b0;
        fetch(11'h012);
        chk("guard_data", v, 8'h77);
    endtask
    task automatic t_irq();
        i_core.wr(EBAC_SEL_CTRL, 8'h0C);
        i_core.wr(EBAC_SEL_CTRL, 8'h0E);
        @(posedge mclk_i);
        glb_ie <= 1'b1;
        repeat (2) @(posedge mclk_i);
        #1 chk("irq_busy", {7'h00, irq}, 8'h00);
        wait_done();
        repeat (2) @(posedge mclk_i);
        #1 chk("irq_ready", {7'h00, irq}, 8'h01);
        @(posedge mclk_i);
        glb_ie <= 1'b0;
    endtask
    task automatic t_rst_mid();
        prog(2'h1, 11'h012, 8'h00);
        pulse_rst();
        i_core.rd(EBAC_SEL_CTRL, v);
        chk("rst_keep_mode", v & 8'h32, 8'h12);
        wait_done();
        fetch(11'h012);
        chk("rst_write_done", v, 8'hFF);
        i_core.wr(EBAC_SEL_CTRL, 8'h10);
        pulse_rst();
        i_core.rd(EBAC_SEL_CTRL, v);
        chk("rst_clear_mode", v & 8'h30, 8'h00);
    endtask
    // ====
    // main sequence and watchdog
    initial begin
        // non-blocking so the reset edge is seen by every asynchronously reset flop at time zero
        {rstn_i, glb_ie, flash_en} <= 3'h0;
        repeat (16) @(posedge mclk_i);
        rstn_i <= 1'b1;
        i_core.rd(EBAC_SEL_CTRL, v);
        chk("ctrl_reset", v & 8'hFD, 8'h00);
        i_core.rd(EBAC_SEL_DATA, v);
        chk("data_reset", v, EBAC_DATA_RESET);
        i_core.wr(EBAC_SEL_ADDR_H, 8'hFF);
        i_core.rd(EBAC_SEL_ADDR_H, v);
        chk("addr_high", v, 8'h07);
        t_modes();
        t_busy();
        t_guard();
        t_irq();
        t_rst_mid();
        end_sim();
    end
    initial begin
        repeat (6000) @(posedge mclk_i);
        err_count++;
        end_sim();
    end
endmodule
